// >>> core/trb_pkg.sv
// shared constants and types for the trace buffer controller and its partner
package trb_pkg;
  // ===================================================================
  // widths
  localparam int ADDR_W = 13;
  localparam int PTR_W = 9;
  localparam int MASK_W = 5;
  localparam int IRQ_W = 4;
  localparam int RAM_WORDS = 1024;
  localparam int RAM_AW = 10;
  localparam int HADDR_W = 5;
  localparam logic [MASK_W-1:0] MASK_MAX = 5'h08;
  localparam logic [PTR_W-1:0] WM_MARGIN = 9'h004;

  // ===================================================================
  // device register map, bit 12 of the address selects trace ram
  localparam int RAM_SEL_BIT = 12;
  localparam logic [11:0] OFS_POSITION = 12'h000;
  localparam logic [11:0] OFS_MASTER = 12'h004;
  localparam logic [11:0] OFS_FLOW = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFS_IRQ_EN = 12'h014;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h018;

  // ===================================================================
  // field positions
  localparam int PB_PTR_LO = 3;
  localparam int PB_PTR_HI = 11;
  localparam int PB_WRAP = 2;
  localparam int MB_EN = 31;
  localparam int MB_HALT = 9;
  localparam int MB_RAM_PRIVILEGE_BIT = 8;
  localparam int MB_SFRW = 7;
  localparam int MB_STOPEN = 6;
  localparam int MB_STARTEN = 5;
  localparam int FB_AUTOHALT = 1;
  localparam int FB_AUTOSTOP = 0;
  localparam int IB_WMARK = 0;
  localparam int IB_WRAP = 1;
  localparam int IB_START = 2;
  localparam int IB_STOP = 3;

  // ===================================================================
  // reset values
  localparam logic [31:0] MASTER_RST = 32'h0000_0080;

  // ===================================================================
  // partner command registers
  localparam logic [HADDR_W-1:0] HOFS_CFG = 5'h00;
  localparam logic [HADDR_W-1:0] HOFS_WM = 5'h04;
  localparam logic [HADDR_W-1:0] HOFS_ACC = 5'h08;
  localparam logic [HADDR_W-1:0] HOFS_ADATA = 5'h0c;
  localparam logic [HADDR_W-1:0] HOFS_STAT = 5'h10;
  localparam int HC_AUTOSTOP = 5;
  localparam int HC_AUTOHALT = 6;
  localparam int HC_STARTEN = 7;
  localparam int HC_STOPEN = 8;
  localparam int HC_INVASIVE_DEBUG_ENABLE = 9;
  localparam int HC_GO = 10;
  localparam int HC_TRACE_START_INPUT = 11;
  localparam int HC_TRACE_STOP_INPUT = 12;
  localparam int HA_WRITE = 16;
  localparam int HA_PRIV = 17;

  typedef enum logic [0:0] {PK_IDLE = 1'b0, PK_WORD1 = 1'b1} trb_pk_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_POS = 3'b001, H_FLOW = 3'b010,
    H_MASTER = 3'b011, H_ACC = 3'b100, H_RDWAIT = 3'b101
  } trb_hst_t;
endpackage

// >>> core/trb_if.sv
// link between the trace buffer controller and its processor-side partner
`timescale 1ns/1ps
`default_nettype none
interface trb_if;
  import trb_pkg::*;
  logic bus_sel;
  logic bus_write;
  logic bus_priv;
  logic [ADDR_W-1:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic pkt_valid;
  logic [31:0] pkt_w0;
  logic [31:0] pkt_w1;
  logic pkt_ready;
  logic trace_start_input;
  logic trace_stop_input;
  logic dbg_en;
  logic halt;
  modport dev (input bus_sel, bus_write, bus_priv, bus_addr, bus_wdata, pkt_valid, pkt_w0,
    pkt_w1, trace_start_input, trace_stop_input, dbg_en, output bus_rdata, pkt_ready, halt);
  modport host (output bus_sel, bus_write, bus_priv, bus_addr, bus_wdata, pkt_valid, pkt_w0,
    pkt_w1, trace_start_input, trace_stop_input, dbg_en, input bus_rdata, pkt_ready, halt);
endinterface
`default_nettype wire

// >>> core/trb_dev.sv
// trace buffer controller: master control, flow control and circular trace ram
//
// How it works
// - software sets position and flow before enabling
// - mask must not wrap before watermark
// - enabled: store packet, then bump pointer
// - start input with enable sets trace enable
// - stop input clears enable, packet finishes
// - watermark stop blocks start-input restart
// - halt bit drives halt when debug enabled
// - ram privilege bit: user ram access razwi
// - write privilege bit: user register writes ignored
// - master bits 30..10 read zero
// - wrap sets flag, clears masked pointer bits
// - buffer is 2^(mask+4) bytes, mask clamped
// - autostop holds until pointer or watermark rewritten, or autostop cleared
// - autohalt watermark sits below last entry
// - pointer hits watermark: autostop, autohalt act
// - packet is two words, pointer counts packets
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module trb_dev
  import trb_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  trb_if.dev link, // bus, trace packets, debug pins
  output logic irq // level interrupt
);

  // ===================================================================
  // state
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic wrap;
    logic en;
    logic halt_request_bit;
    logic ram_privilege_bit;
    logic register_write_privilege_bit;
    logic stopen;
    logic starten;
    logic [MASK_W-1:0] mask;
    logic [PTR_W-1:0] wmark;
    logic autohalt;
    logic autostop;
    logic wm_stop;
    trb_pk_t pk;
    logic [31:0] w1;
    logic [31:0] rdata;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic halt;
    logic ready;
  } trb_dev_t;

  trb_dev_t s_q;
  trb_dev_t s_d;
  logic [31:0] mem [RAM_WORDS];
  logic [MASK_W-1:0] mclamp;
  logic [PTR_W-1:0] lowm;
  logic wrapping;
  logic [PTR_W-1:0] ptr_nx;
  logic [IRQ_W-1:0] ev;
  logic ram_we;
  logic [RAM_AW-1:0] ram_wa;
  logic [31:0] ram_wd;
  logic user_acc;
  logic reg_wr;
  logic [11:0] ofs;

  // ===================================================================
  // buffer size arithmetic
  // mask clamped to ram size
  assign mclamp = (s_q.mask > MASK_MAX) ? MASK_MAX : s_q.mask;

  // one bit per pointer bit: set where the increment may touch it
  for (genvar i = 0; i < PTR_W; i++) begin : g_lowm
    assign lowm[i] = (MASK_W'(i) <= mclamp);
  end

  // wrap clears only the masked bits
  assign wrapping = ((s_q.ptr & lowm) == lowm);
  assign ptr_nx = wrapping ? (s_q.ptr & ~lowm) : PTR_W'(s_q.ptr + 1'b1);

  assign user_acc = !link.bus_priv;
  assign ofs = link.bus_addr[11:0];
  // user writes dropped under write privilege
  assign reg_wr = link.bus_sel & link.bus_write & !link.bus_addr[RAM_SEL_BIT]
    & !(s_q.register_write_privilege_bit & user_acc);

  // ===================================================================
  // next state
  always_comb begin
    s_d = s_q;
    ev = '0;
    ram_we = 1'b0;
    ram_wa = '0;
    ram_wd = '0;
    s_d.rdata = '0;

    // two words per packet, pointer in packet units
    unique case (s_q.pk)
      PK_IDLE: begin
        if (link.pkt_valid && s_q.ready) begin
          ram_we = 1'b1;
          ram_wa = {s_q.ptr, 1'b0};
          ram_wd = link.pkt_w0;
          s_d.w1 = link.pkt_w1;
          s_d.pk = PK_WORD1;
        end
      end
      PK_WORD1: begin
        // second word goes out even if enable dropped meanwhile
        ram_we = 1'b1;
        ram_wa = {s_q.ptr, 1'b1};
        ram_wd = s_q.w1;
        s_d.pk = PK_IDLE;
        s_d.ptr = ptr_nx;
        if (wrapping) begin
          s_d.wrap = 1'b1;
          ev[IB_WRAP] = 1'b1;
        end
        if (ptr_nx == s_q.wmark && (s_q.autostop || s_q.autohalt)) begin
          ev[IB_WMARK] = 1'b1;
          if (s_q.autostop) begin
            s_d.en = 1'b0;
            s_d.wm_stop = 1'b1;
          end
          if (s_q.autohalt) begin
            s_d.halt_request_bit = 1'b1;
          end
        end
      end
    endcase

    if (s_q.starten && link.trace_start_input && !s_d.wm_stop && !s_q.en) begin
      s_d.en = 1'b1;
      ev[IB_START] = 1'b1;
    end
    if (s_q.stopen && link.trace_stop_input && s_d.en) begin
      s_d.en = 1'b0;
      ev[IB_STOP] = 1'b1;
    end

    // register writes land after hardware updates
    if (reg_wr) begin
      unique case (ofs)
        OFS_POSITION: begin
          s_d.ptr = link.bus_wdata[PB_PTR_HI:PB_PTR_LO];
          s_d.wrap = link.bus_wdata[PB_WRAP];
          // rewriting the pointer releases autostop, unless it fires now
          s_d.wm_stop = ev[IB_WMARK] & s_q.autostop;
        end
        OFS_MASTER: begin
          s_d.en = link.bus_wdata[MB_EN];
          // halt bit only cleared here; a watermark set this cycle wins
          s_d.halt_request_bit = link.bus_wdata[MB_HALT] | (ev[IB_WMARK] & s_q.autohalt);
          s_d.ram_privilege_bit = link.bus_wdata[MB_RAM_PRIVILEGE_BIT];
          s_d.register_write_privilege_bit = link.bus_wdata[MB_SFRW];
          s_d.stopen = link.bus_wdata[MB_STOPEN];
          s_d.starten = link.bus_wdata[MB_STARTEN];
          s_d.mask = link.bus_wdata[MASK_W-1:0];
        end
        OFS_FLOW: begin
          s_d.wmark = link.bus_wdata[PB_PTR_HI:PB_PTR_LO];
          s_d.autohalt = link.bus_wdata[FB_AUTOHALT];
          s_d.autostop = link.bus_wdata[FB_AUTOSTOP];
          // new watermark or autostop off releases the stop; a stop now wins
          if (!link.bus_wdata[FB_AUTOSTOP]
              || link.bus_wdata[PB_PTR_HI:PB_PTR_LO] != s_q.wmark) begin
            s_d.wm_stop = ev[IB_WMARK] & s_q.autostop;
          end
        end
        OFS_IRQ_EN: s_d.ien = link.bus_wdata[IRQ_W-1:0];
        OFS_IRQ_CLR: s_d.ist = s_q.ist & ~link.bus_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    s_d.ist = s_d.ist | ev;

    // reads, answered in the following cycle
    if (link.bus_sel && !link.bus_write) begin
      if (link.bus_addr[RAM_SEL_BIT]) begin
        // user ram reads see zero under ram privilege
        if (!(s_q.ram_privilege_bit && user_acc)) begin
          s_d.rdata = mem[link.bus_addr[RAM_AW+1:2]];
        end
      end else begin
        unique case (ofs)
          OFS_POSITION: s_d.rdata = {20'h0_0000, s_q.ptr, s_q.wrap, 2'h0};
          OFS_MASTER: s_d.rdata = {s_q.en, 21'h00_0000, s_q.halt_request_bit, s_q.ram_privilege_bit,
            s_q.register_write_privilege_bit, s_q.stopen, s_q.starten, s_q.mask};
          OFS_FLOW: s_d.rdata = {20'h0_0000, s_q.wmark, 1'b0, s_q.autohalt, s_q.autostop};
          OFS_IRQ_STAT: s_d.rdata = {28'h000_0000, s_q.ist};
          OFS_IRQ_EN: s_d.rdata = {28'h000_0000, s_q.ien};
          default: s_d.rdata = '0;
        endcase
      end
    end

    // user ram writes ignored under ram privilege; trace writes take the port first
    if (!ram_we && link.bus_sel && link.bus_write && link.bus_addr[RAM_SEL_BIT]
        && !(s_q.ram_privilege_bit && user_acc)) begin
      ram_we = 1'b1;
      ram_wa = link.bus_addr[RAM_AW+1:2];
      ram_wd = link.bus_wdata;
    end

    s_d.irq = |(s_d.ist & s_d.ien);
    // halt gated by invasive debug enable
    s_d.halt = s_d.halt_request_bit & link.dbg_en;
    s_d.ready = s_d.en & (s_d.pk == PK_IDLE);
  end

  // ===================================================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.register_write_privilege_bit <= MASTER_RST[MB_SFRW];
    end else begin
      s_q <= s_d;
    end
  end

  // trace ram has no reset; contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (ram_we) begin
      mem[ram_wa] <= ram_wd;
    end
  end

  assign link.bus_rdata = s_q.rdata;
  assign link.pkt_ready = s_q.ready;
  assign link.halt = s_q.halt;
  assign irq = s_q.irq;

endmodule
`default_nettype wire

// >>> core/trb_host.sv
// processor-side partner: programs the trace controller and feeds packets
`timescale 1ns/1ps
`default_nettype none
module trb_host
  import trb_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  trb_if.host link, // toward the trace controller
  input wire logic [HADDR_W-1:0] cmd_addr, // command register address
  input wire logic [31:0] cmd_wdata, // command write data
  input wire logic cmd_wr, // write strobe
  input wire logic cmd_rd, // read strobe
  output logic [31:0] cmd_rdata, // read data, cycle after strobe
  input wire logic upkt_valid, // user packet offered
  input wire logic [31:0] upkt_w0, // first packet word
  input wire logic [31:0] upkt_w1, // second packet word
  output logic upkt_ready, // packet slot free
  output logic halt_flag // sticky halt seen
);

  // ===================================================================
  // state
  typedef struct packed {
    trb_hst_t st;
    logic [12:0] cfg;
    logic [PTR_W-1:0] wm;
    logic [17:0] acc;
    logic [31:0] adata;
    logic halt_seen;
    logic [31:0] rdata;
    logic sel;
    logic write;
    logic priv;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic trace_start_input;
    logic trace_stop_input;
    logic pv;
    logic [31:0] w0;
    logic [31:0] w1;
    logic urdy;
  } trb_host_t;

  trb_host_t s_q;
  trb_host_t s_d;
  logic [MASK_W-1:0] mclamp;
  logic [PTR_W-1:0] lowm;
  logic [PTR_W-1:0] wm_in;
  logic [PTR_W-1:0] wm_eff;
  logic busy;

  // ===================================================================
  // watermark placement
  assign mclamp = (s_q.cfg[MASK_W-1:0] > MASK_MAX) ? MASK_MAX : s_q.cfg[MASK_W-1:0];
  for (genvar i = 0; i < PTR_W; i++) begin : g_lowm
    assign lowm[i] = (MASK_W'(i) <= mclamp);
  end
  // keep watermark inside the buffer so no wrap precedes it
  assign wm_in = s_q.wm & lowm;
  // autohalt leaves room for branches before debug state
  assign wm_eff = !s_q.cfg[HC_AUTOHALT] ? wm_in :
    (lowm < WM_MARGIN) ? '0 :
    (wm_in > PTR_W'(lowm - WM_MARGIN)) ? PTR_W'(lowm - WM_MARGIN) : wm_in;
  assign busy = (s_q.st != H_IDLE);

  // ===================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.sel = 1'b0;
    s_d.write = 1'b0;
    s_d.trace_start_input = 1'b0;
    s_d.trace_stop_input = 1'b0;
    s_d.rdata = '0;

    unique case (s_q.st)
      H_IDLE: ;
      H_POS: begin
        s_d.sel = 1'b1;
        s_d.write = 1'b1;
        s_d.priv = 1'b1;
        s_d.addr = {1'b0, OFS_POSITION};
        s_d.wdata = '0;
        s_d.st = H_FLOW;
      end
      H_FLOW: begin
        s_d.sel = 1'b1;
        s_d.write = 1'b1;
        s_d.addr = {1'b0, OFS_FLOW};
        s_d.wdata = {20'h0_0000, wm_eff, 1'b0, s_q.cfg[HC_AUTOHALT], s_q.cfg[HC_AUTOSTOP]};
        s_d.st = H_MASTER;
      end
      // enables only after position and flow
      H_MASTER: begin
        s_d.sel = 1'b1;
        s_d.write = 1'b1;
        s_d.addr = {1'b0, OFS_MASTER};
        s_d.wdata = MASTER_RST;
        s_d.wdata[MB_EN] = !s_q.cfg[HC_STARTEN];
        s_d.wdata[MB_STARTEN] = s_q.cfg[HC_STARTEN];
        s_d.wdata[MB_STOPEN] = s_q.cfg[HC_STOPEN];
        s_d.wdata[MASK_W-1:0] = s_q.cfg[MASK_W-1:0];
        s_d.st = H_IDLE;
      end
      H_ACC: begin
        s_d.sel = 1'b1;
        s_d.write = s_q.acc[HA_WRITE];
        s_d.priv = s_q.acc[HA_PRIV];
        s_d.addr = s_q.acc[ADDR_W-1:0];
        s_d.wdata = s_q.adata;
        s_d.st = s_q.acc[HA_WRITE] ? H_IDLE : H_RDWAIT;
      end
      // read data stand one cycle after the select, so wait while it is still up
      H_RDWAIT: begin
        if (!s_q.sel) begin
          s_d.adata = link.bus_rdata;
          s_d.st = H_IDLE;
        end
      end
      default: s_d.st = H_IDLE;
    endcase

    // command writes; sequence triggers ignored while busy
    if (cmd_wr) begin
      unique case (cmd_addr)
        HOFS_CFG: begin
          s_d.cfg = cmd_wdata[12:0];
          s_d.cfg[HC_GO] = 1'b0;
          s_d.trace_start_input = cmd_wdata[HC_TRACE_START_INPUT];
          s_d.trace_stop_input = cmd_wdata[HC_TRACE_STOP_INPUT];
          if (cmd_wdata[HC_GO] && !busy) begin
            s_d.st = H_POS;
          end
        end
        HOFS_WM: s_d.wm = cmd_wdata[PTR_W-1:0];
        HOFS_ACC: begin
          if (!busy) begin
            s_d.acc = cmd_wdata[17:0];
            s_d.st = H_ACC;
          end
        end
        HOFS_ADATA: if (!busy) s_d.adata = cmd_wdata;
        HOFS_STAT: s_d.halt_seen = 1'b0;
        default: ;
      endcase
    end
    // set wins over clear
    if (link.halt) begin
      s_d.halt_seen = 1'b1;
    end

    if (cmd_rd) begin
      unique case (cmd_addr)
        HOFS_CFG: s_d.rdata = {19'h0_0000, s_q.cfg};
        HOFS_WM: s_d.rdata = {23'h00_0000, s_q.wm};
        HOFS_ACC: s_d.rdata = {14'h0000, s_q.acc};
        HOFS_ADATA: s_d.rdata = s_q.adata;
        HOFS_STAT: s_d.rdata = {30'h0000_0000, s_q.halt_seen, busy};
        default: s_d.rdata = '0;
      endcase
    end

    // single packet slot between user and controller
    if (s_q.pv && link.pkt_ready) begin
      s_d.pv = 1'b0;
      s_d.urdy = 1'b1;
    end else if (upkt_valid && s_q.urdy) begin
      s_d.pv = 1'b1;
      s_d.urdy = 1'b0;
      s_d.w0 = upkt_w0;
      s_d.w1 = upkt_w1;
    end
  end

  // ===================================================================
  // registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.urdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.bus_sel = s_q.sel;
  assign link.bus_write = s_q.write;
  assign link.bus_priv = s_q.priv;
  assign link.bus_addr = s_q.addr;
  assign link.bus_wdata = s_q.wdata;
  assign link.pkt_valid = s_q.pv;
  assign link.pkt_w0 = s_q.w0;
  assign link.pkt_w1 = s_q.w1;
  assign link.trace_start_input = s_q.trace_start_input;
  assign link.trace_stop_input = s_q.trace_stop_input;
  assign link.dbg_en = s_q.cfg[HC_INVASIVE_DEBUG_ENABLE];
  assign cmd_rdata = s_q.rdata;
  assign upkt_ready = s_q.urdy;
  assign halt_flag = s_q.halt_seen;

endmodule
`default_nettype wire

// >>> bench/trb_props.sv
// concurrent checks on the controller link
`timescale 1ns/1ps
`default_nettype none
module trb_props
  import trb_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic rst, // async reset
  input wire logic bus_sel, // access
  input wire logic bus_write, // write
  input wire logic bus_priv, // privileged
  input wire logic [ADDR_W-1:0] bus_addr, // address
  input wire logic [31:0] bus_wdata, // write data
  input wire logic [31:0] bus_rdata, // read data
  input wire logic pkt_valid, // packet offered
  input wire logic pkt_ready, // slot open
  input wire logic trace_stop_input, // stop pulse
  input wire logic dbg_en, // debug enable
  input wire logic halt // halt out
);
  // ====
  // helper: shadow of the software bits
  logic [31:0] mst_q;
  logic rd_m;
  logic wr_m;
  // user writes drop out while bit 7 is set
  assign rd_m = bus_sel && !bus_write && (bus_addr == {1'h0, OFS_MASTER});
  assign wr_m = bus_sel && bus_write && (bus_addr == {1'h0, OFS_MASTER})
      && (bus_priv || !mst_q[MB_SFRW]);
  // bits 8..5 are never moved by hardware, so the shadow stays exact there
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mst_q <= MASTER_RST;
    end else if (wr_m) begin
      mst_q <= bus_wdata;
    end
  end
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ====
  // halt needs debug
  AST_HALT_GATED: assert property (!dbg_en |=> !halt)
    else $error("halt without debug enable");
  AST_HALT_SET: assert property (wr_m && bus_wdata[MB_HALT] ##1 dbg_en |=> halt)
    else $error("halt bit written but no halt");
  AST_HALT_HOLDS: assert property (halt && dbg_en && !wr_m && !$past(wr_m) |=> halt)
    else $error("halt dropped on its own");
  AST_PKT_TWO_WORDS: assert property (pkt_valid && pkt_ready |=> !pkt_ready)
    else $error("packet slot open during second word");
  AST_MST_RSVD: assert property (rd_m |=> bus_rdata[30:10] == 21'h0)
    else $error("reserved master bits not zero");
  AST_MST_SW_BITS: assert property (rd_m |=> bus_rdata[8:5] == $past(mst_q[8:5]))
    else $error("master control bits differ from accepted writes");
  AST_STOP_CLEARS: assert property (trace_stop_input && mst_q[MB_STOPEN] |-> ##2 !pkt_ready)
    else $error("tracing went on after stop");
  AST_RAM_USER_RAZ: assert property (bus_sel && !bus_write && !bus_priv
      && bus_addr[RAM_SEL_BIT] && mst_q[MB_RAM_PRIVILEGE_BIT] |=> bus_rdata == 32'h0)
    else $error("user ram read returned data");
endmodule
`default_nettype wire

// >>> bench/trace_buffer_master_flow_control_test.sv
// bench: host and trace controller joined by their link
`timescale 1ns/1ps
`default_nettype none
module trace_buffer_master_flow_control_test;
  import trb_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [HADDR_W-1:0] cmd_addr = 5'h00;
  logic [31:0] cmd_wdata = 32'h0;
  logic cmd_wr = 1'h0;
  logic cmd_rd = 1'h0;
  logic [31:0] cmd_rdata;
  logic upkt_valid = 1'h0;
  logic [31:0] upkt_w0 = 32'h0;
  logic [31:0] upkt_w1 = 32'h0;
  logic upkt_ready;
  logic halt_flag;
  logic irq;
  logic [31:0] rd;
  int n_fail = 0;
  int checks_done = 0;
  localparam logic [12:0] A_MST = {1'h0, OFS_MASTER};
  localparam logic [12:0] A_POS = {1'h0, OFS_POSITION};
  trb_if link ();
  trb_dev u_trb_dev (.sys_clk(sys_clk), .rst(rst), .link(link.dev), .irq(irq));
  trb_host u_trb_host (.sys_clk(sys_clk), .rst(rst), .link(link.host), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .upkt_valid(upkt_valid), .upkt_w0(upkt_w0), .upkt_w1(upkt_w1),
    .upkt_ready(upkt_ready), .halt_flag(halt_flag));
  trb_props u_trb_props (.sys_clk(sys_clk), .rst(rst), .bus_sel(link.bus_sel),
    .bus_write(link.bus_write), .bus_priv(link.bus_priv), .bus_addr(link.bus_addr),
    .bus_wdata(link.bus_wdata), .bus_rdata(link.bus_rdata), .pkt_valid(link.pkt_valid),
    .pkt_ready(link.pkt_ready), .trace_stop_input(link.trace_stop_input), .dbg_en(link.dbg_en), .halt(link.halt));
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // ====
  // reporting
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang(input string what);
    n_fail++;
    $display("BAD %0t %s", $time, what);
    test_done();
  endtask
  // ====
  // command port; one idle cycle after each strobe keeps drivers apart
  task automatic cwr(input logic [HADDR_W-1:0] a, input logic [31:0] d);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'h1;
    @(posedge sys_clk);
    cmd_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic crd(input logic [HADDR_W-1:0] a, output logic [31:0] d);
    cmd_addr <= a;
    cmd_rd <= 1'h1;
    @(posedge sys_clk);
    cmd_rd <= 1'h0;
    #1 d = cmd_rdata;
    @(posedge sys_clk);
  endtask
  task automatic idle();
    logic [31:0] s;
    for (int i = 0; i < 40; i++) begin
      crd(HOFS_STAT, s);
      if (s[0] === 1'h0) return;
    end
    hang("host stays busy");
  endtask
  // raw device access through the host
  task automatic acc(input logic [12:0] a, input logic w, input logic p,
      input logic [31:0] wd, output logic [31:0] d);
    cwr(HOFS_ADATA, wd);
    cwr(HOFS_ACC, {14'h0, p, w, 3'h0, a});
    idle();
    crd(HOFS_ADATA, d);
  endtask
  task automatic rchk(input logic [12:0] a, input logic [31:0] e);
    acc(a, 1'h0, 1'h1, 32'h0, rd);
    chk(rd, e);
  endtask
  function automatic logic [12:0] ram(input int w);
    return {1'h1, 10'(w), 2'h0};
  endfunction
  task automatic arm(input logic [31:0] wm, input logic [31:0] c);
    cwr(HOFS_WM, wm);
    cwr(HOFS_CFG, c | 32'h400);
    idle();
  endtask
  task automatic pkt(input logic [31:0] w0, input logic [31:0] w1);
    upkt_w0 <= w0;
    upkt_w1 <= w1;
    upkt_valid <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (upkt_ready === 1'h1) begin
        @(posedge sys_clk);
        upkt_valid <= 1'h0;
        @(posedge sys_clk);
        return;
      end
      @(posedge sys_clk);
    end
    hang("packet never taken");
  endtask
  // ====
  // scenarios
  task automatic s_trace();
    arm(32'h1ff, 32'h008);
    for (int i = 0; i < 3; i++) begin
      pkt(32'ha000 + i, 32'hb000 + i);
    end
    rchk(A_POS, 32'h18);
    rchk(A_MST, 32'h8000_0088);
    for (int i = 0; i < 3; i++) begin
      rchk(ram(2 * i), 32'ha000 + i);
      rchk(ram(2 * i + 1), 32'hb000 + i);
    end
  endtask
  // mask 0 gives a two packet ring above pointer 0x20
  task automatic s_wrap();
    arm(32'h1ff, 32'h080);
    acc(A_POS, 1'h1, 1'h1, 32'h100, rd);
    acc({1'h0, OFS_IRQ_EN}, 1'h1, 1'h1, 32'h2, rd);
    cwr(HOFS_CFG, 32'h880);
    rchk(A_MST, 32'h8000_00a0);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pkt(32'hc000 + i, 32'hd000 + i);
    end
    rchk(A_POS, 32'h10c);
    rchk(ram(32'h40), 32'hc002);
    chk({31'h0, irq}, 32'h1);
    acc({1'h0, OFS_IRQ_CLR}, 1'h1, 1'h1, 32'h2, rd);
    chk({31'h0, irq}, 32'h0);
    // mask above the maximum acts as the maximum: the last slot wraps to 0
    arm(32'h1ff, 32'h010);
    acc(A_POS, 1'h1, 1'h1, 32'hff8, rd);
    pkt(32'h1, 32'h2);
    rchk(A_POS, 32'h4);
  endtask
  task automatic s_stop();
    arm(32'h1ff, 32'h108);
    cwr(HOFS_CFG, 32'h1108);
    rchk(A_MST, 32'h0000_00c8);
    chk({31'h0, link.pkt_ready}, 32'h0);
  endtask
  task automatic s_wmstop();
    arm(32'h2, 32'h0a8);
    cwr(HOFS_CFG, 32'h8a8);
    pkt(32'he000, 32'he001);
    pkt(32'he002, 32'he003);
    rchk(A_MST, 32'h0000_00a8);
    rchk(A_POS, 32'h10);
    cwr(HOFS_CFG, 32'h8a8);
    rchk(A_MST, 32'h0000_00a8);
    acc(A_POS, 1'h1, 1'h1, 32'h0, rd);
    cwr(HOFS_CFG, 32'h8a8);
    rchk(A_MST, 32'h8000_00a8);
  endtask
  task automatic s_halt();
    arm(32'h2, 32'h248);
    pkt(32'hf000, 32'hf001);
    pkt(32'hf002, 32'hf003);
    rchk(A_MST, 32'h8000_0288);
    chk({31'h0, link.halt}, 32'h1);
    chk({31'h0, halt_flag}, 32'h1);
    cwr(HOFS_CFG, 32'h048);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, link.halt}, 32'h0);
    cwr(HOFS_CFG, 32'h248);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, link.halt}, 32'h1);
    acc(A_MST, 1'h1, 1'h1, 32'h8000_0088, rd);
    chk({31'h0, link.halt}, 32'h0);
    acc(A_MST, 1'h1, 1'h1, 32'h8000_0288, rd);
    chk({31'h0, link.halt}, 32'h1);
    acc(A_MST, 1'h1, 1'h1, 32'h8000_0088, rd);
  endtask
  // tracing held off so bus ram writes never collide with packets
  task automatic s_priv();
    arm(32'h1ff, 32'h088);
    acc(A_MST, 1'h1, 1'h0, 32'h0, rd);
    rchk(A_MST, 32'h0000_00a8);
    acc(A_MST, 1'h0, 1'h0, 32'h0, rd);
    chk(rd, 32'h0000_00a8);
    acc(ram(16), 1'h1, 1'h0, 32'h5a5a_0001, rd);
    rchk(ram(16), 32'h5a5a_0001);
    acc(A_MST, 1'h1, 1'h1, 32'h0000_01a8, rd);
    acc(ram(16), 1'h1, 1'h0, 32'h0bad_0bad, rd);
    rchk(ram(16), 32'h5a5a_0001);
    acc(ram(16), 1'h0, 1'h0, 32'h0, rd);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    rchk(A_MST, MASTER_RST);
    rchk(13'h0fc, 32'h0);
    s_trace();
    s_wrap();
    s_stop();
    s_wmstop();
    s_halt();
    s_priv();
    test_done();
  end
endmodule
`default_nettype wire
